// ---- src/beep_pkg.sv ----
// constants, codes and pattern types for the fault annunciator
// assumes a single 125 MHz system clock
package beep_pkg;

  localparam int CLK_KHZ       = 125000;
  // pattern times in milliseconds
  localparam int LONG_ON_MS    = 600;
  localparam int LONG_GAP_MS   = 600;
  localparam int SHORT_ON_MS   = 200;
  localparam int SHORT_GAP_MS  = 200;
  localparam int GROUP_GAP_MS  = 1200;
  localparam int CONT_ON_MS    = 2000;
  localparam int LONG_ON_CYC   = LONG_ON_MS * CLK_KHZ;
  localparam int LONG_GAP_CYC  = LONG_GAP_MS * CLK_KHZ;
  localparam int SHORT_ON_CYC  = SHORT_ON_MS * CLK_KHZ;
  localparam int SHORT_GAP_CYC = SHORT_GAP_MS * CLK_KHZ;
  localparam int GROUP_GAP_CYC = GROUP_GAP_MS * CLK_KHZ;
  localparam int CONT_ON_CYC   = CONT_ON_MS * CLK_KHZ;
  localparam int STEP_LIMIT    = 4000;

  localparam int NUM_AXES      = 4;
  localparam int CODE_W        = 7;
  localparam int DETAIL_W      = 48;
  // axis order: 0 = z, 1 = x, 2 = y, 3 = r
  localparam logic [CODE_W-1:0] CODE_Z_SENSOR = 7'h59;
  localparam logic [CODE_W-1:0] CODE_Z_INDEX  = 7'h5a;
  localparam logic [CODE_W-1:0] CODE_X_SENSOR = 7'h5c;
  localparam logic [CODE_W-1:0] CODE_X_INDEX  = 7'h5d;
  localparam logic [CODE_W-1:0] CODE_Y_SENSOR = 7'h5f;
  localparam logic [CODE_W-1:0] CODE_Y_INDEX  = 7'h60;
  localparam logic [CODE_W-1:0] CODE_R_SENSOR = 7'h62;
  localparam logic [CODE_W-1:0] CODE_R_INDEX  = 7'h63;
  localparam logic [CODE_W-1:0] CODE_LOGIC    = 7'h64;
  localparam logic [CODE_W-1:0] CODE_TRAP     = 7'h65;
  localparam logic [CODE_W-1:0] CODE_NONE     = 7'h00;

  typedef enum logic [2:0] {
    PAT_NONE      = 3'h0,
    PAT_ONE_LONG  = 3'h1,
    PAT_TWO_LONG  = 3'h2,
    PAT_TWO_SHORT = 3'h3,
    PAT_CONT      = 3'h4
  } pattern_e;

endpackage

// ---- src/beep_if.sv ----
// carrier between the fault latch and the beep sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface beep_if;
  import beep_pkg::*;
  pattern_e pattern;
  logic     start;
  logic     buzzer;
  logic     busy;
  modport ctrl (output pattern, output start, input buzzer, input busy);
  modport seq  (input pattern, input start, output buzzer, output busy);
endinterface
`default_nettype wire

// ---- src/beep_sequencer.sv ----
// beep sequencer: plays one pattern from start until reset
// assumes start is a one-cycle pulse and pattern is stable with it
`timescale 1ns/1ps
`default_nettype none
module beep_sequencer
  import beep_pkg::*;
#(
  parameter int LONG_ON   = LONG_ON_CYC,
  parameter int LONG_GAP  = LONG_GAP_CYC,
  parameter int SHORT_ON  = SHORT_ON_CYC,
  parameter int SHORT_GAP = SHORT_GAP_CYC,
  parameter int GROUP_GAP = GROUP_GAP_CYC,
  parameter int CONT_ON   = CONT_ON_CYC
) (
  input  wire logic ref_clk, // system clock
  input  wire logic resetn,  // async reset, active low
  beep_if.seq       bif      // pattern request and buzzer
);

  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_ON1  = 6'b00_0010,
    S_GAP1 = 6'b00_0100,
    S_ON2  = 6'b00_1000,
    S_GAP2 = 6'b01_0000,
    S_DONE = 6'b10_0000
  } seq_state_e;

  seq_state_e    state_r, state_nxt;
  pattern_e      pat_r;
  logic [31:0]   cnt_r;
  logic [31:0]   len_w;
  logic          last_w;
  logic          is_long_w;
  logic          buzz_r;

  assign is_long_w = (pat_r == PAT_ONE_LONG) || (pat_r == PAT_TWO_LONG);
  // length of the current phase; on time depends on the pattern
  assign len_w = (pat_r == PAT_CONT)                     ? 32'(CONT_ON)   :
                 (state_r == S_GAP2)                     ? 32'(GROUP_GAP) :
                 (state_r == S_GAP1 && is_long_w)        ? 32'(LONG_GAP)  :
                 (state_r == S_GAP1)                     ? 32'(SHORT_GAP) :
                 is_long_w                               ? 32'(LONG_ON)   :
                                                           32'(SHORT_ON);
  assign last_w = (cnt_r == len_w - 32'd1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (bif.start && bif.pattern != PAT_NONE) state_nxt = S_ON1;
      S_ON1: begin
        if (last_w) begin
          if (pat_r == PAT_CONT) state_nxt = S_DONE;
          else if (pat_r == PAT_ONE_LONG) state_nxt = S_GAP2;
          else state_nxt = S_GAP1;
        end
      end
      S_GAP1: if (last_w) state_nxt = S_ON2;
      S_ON2:  if (last_w) state_nxt = S_GAP2;
      S_GAP2: if (last_w) state_nxt = S_ON1;
      S_DONE: state_nxt = S_DONE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      pat_r   <= PAT_NONE;
      cnt_r   <= 32'h0000_0000;
      buzz_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == S_IDLE && bif.start) pat_r <= bif.pattern;
      cnt_r   <= (state_nxt != state_r) ? 32'h0000_0000 : cnt_r + 32'd1;
      buzz_r  <= (state_nxt == S_ON1) || (state_nxt == S_ON2);
    end
  end

  assign bif.buzzer = buzz_r;
  assign bif.busy   = (state_r != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // checks: width of each burst and of the silence between groups against the pattern
  logic [31:0] on_len_r;
  logic [31:0] off_len_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      on_len_r  <= 32'h0000_0000;
      off_len_r <= 32'h0000_0000;
    end else begin
      on_len_r  <= buzz_r ? on_len_r + 32'd1 : 32'h0000_0000;
      off_len_r <= buzz_r ? 32'h0000_0000 : off_len_r + 32'd1;
    end
  end

  a_long_burst_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(buzz_r) && is_long_w |-> on_len_r == 32'(LONG_ON))
    else $error("long burst has wrong width");
  a_short_burst_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(buzz_r) && pat_r == PAT_TWO_SHORT |-> on_len_r == 32'(SHORT_ON))
    else $error("short burst has wrong width");
  a_group_gap_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(buzz_r) && state_r == S_ON1 && $past(state_r) == S_GAP2
      |-> off_len_r == 32'(GROUP_GAP))
    else $error("gap between groups has wrong width");
  a_cont_burst_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(buzz_r) && pat_r == PAT_CONT |-> on_len_r == 32'(CONT_ON) ##1 state_r == S_DONE)
    else $error("continuous beep has wrong width");
  a_pattern_held: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_r != S_IDLE |=> $stable(pat_r) && state_r != S_IDLE)
    else $error("pattern changed while playing");

  c_two_long: cover property (@(posedge ref_clk) disable iff (!resetn)
    pat_r == PAT_TWO_LONG && state_r == S_ON2);
  c_two_short: cover property (@(posedge ref_clk) disable iff (!resetn)
    pat_r == PAT_TWO_SHORT && state_r == S_GAP2);
  c_cont_done: cover property (@(posedge ref_clk) disable iff (!resetn) state_r == S_DONE);

endmodule
`default_nettype wire

// ---- src/fault_beep_annunciator.sv ----
// fault annunciator: power-on fault beeps and homing fault codes
// assumes checksum, trap and flash results come from logic on ref_clk;
// sensor, index, motor-motion and strap inputs are pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
module fault_beep_annunciator
  import beep_pkg::*;
#(
  parameter int LONG_ON    = LONG_ON_CYC,
  // intra-group gaps follow the on times, so a shortened run keeps their documented ratios
  parameter int LONG_GAP   = int'(longint'(LONG_ON) * LONG_GAP_MS / LONG_ON_MS),
  parameter int SHORT_ON   = SHORT_ON_CYC,
  parameter int SHORT_GAP  = int'(longint'(SHORT_ON) * SHORT_GAP_MS / SHORT_ON_MS),
  parameter int GROUP_GAP  = GROUP_GAP_CYC,
  parameter int CONT_ON    = CONT_ON_CYC,
  parameter int STEP_COUNT = STEP_LIMIT
) (
  input  wire logic                ref_clk,         // system clock, 125 MHz
  input  wire logic                resetn,          // async reset, active low
  input  wire logic                load_mode_pin,   // firmware-load strap, high = load
  input  wire logic                trap_stored_pin, // trap was recorded last session
  input  wire logic                check_done,      // power-on checksum results valid
  input  wire logic                loader_sum_ok,   // loader program checksum good
  input  wire logic                main_sum_ok,     // main program checksum good
  input  wire logic                trap_fault,      // trap event pulse
  input  wire logic                flash_fail,      // loader flash write failed pulse
  input  wire logic                logic_fault,     // logic fault pulse
  input  wire logic [DETAIL_W-1:0] logic_detail,    // six-character detail, with pulse
  input  wire logic                homing_start,    // pulse, clears homing watch
  input  wire logic [NUM_AXES-1:0] step_pulse,      // per-axis step pulse
  input  wire logic [NUM_AXES-1:0] home_pin,        // per-axis home sensor
  input  wire logic [NUM_AXES-1:0] index_pin,       // per-axis encoder index phase
  input  wire logic [NUM_AXES-1:0] moving_pin,      // per-axis motor motion sense
  output logic                     buzzer_on,       // buzzer drive, high = sound
  output logic                     display_blank,   // display suppressed
  output logic                     fault_valid,     // fault code latched
  output logic [CODE_W-1:0]        fault_code,      // numbered fault code
  output logic                     fault_motor,     // sensor/motor fault is motor
  output logic [DETAIL_W-1:0]      fault_detail,    // logic fault detail
  output logic                     prognum_hide,    // keep off program-number display
  output logic                     trap_record,     // store trap for next power-on
  output logic                     pendant_trap     // report stored trap to pendant
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one is read only by stage two
  localparam int PIN_W = 2 + 3 * NUM_AXES;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic             load_mode_w;
  logic             trap_stored_w;
  logic [NUM_AXES-1:0] home_w;
  logic [NUM_AXES-1:0] index_w;
  logic [NUM_AXES-1:0] moving_w;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {load_mode_pin, trap_stored_pin, home_pin, index_pin, moving_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {load_mode_w, trap_stored_w, home_w, index_w, moving_w} = pin_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // power-on fault selection
  beep_if bif ();
  pattern_e pat_r;
  logic     start_r;
  logic     checked_r;
  pattern_e check_pat_w;
  pattern_e new_pat_w;

  // main program is not judged in load mode so that it can be reloaded there
  assign check_pat_w = (load_mode_w && !loader_sum_ok) ? PAT_ONE_LONG :
                       (!load_mode_w && !main_sum_ok)  ? PAT_TWO_LONG :
                                                         PAT_NONE;
  assign new_pat_w = (check_done && !checked_r)   ? check_pat_w   :
                     trap_fault                   ? PAT_TWO_SHORT :
                     (flash_fail && load_mode_w)  ? PAT_CONT      :
                                                    PAT_NONE;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pat_r     <= PAT_NONE;
      start_r   <= 1'b0;
      checked_r <= 1'b0;
    end else begin
      if (check_done) checked_r <= 1'b1;
      start_r <= 1'b0;
      if (pat_r == PAT_NONE && new_pat_w != PAT_NONE) begin
        pat_r   <= new_pat_w;
        start_r <= 1'b1;
      end
    end
  end

  assign bif.pattern = pat_r;
  assign bif.start   = start_r;

  beep_sequencer #(
    .LONG_ON   (LONG_ON),
    .LONG_GAP  (LONG_GAP),
    .SHORT_ON  (SHORT_ON),
    .SHORT_GAP (SHORT_GAP),
    .GROUP_GAP (GROUP_GAP),
    .CONT_ON   (CONT_ON)
  ) u_seq (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bif     (bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // homing watch per axis
  function automatic logic [CODE_W-1:0] axis_code(input int ax, input logic index);
    case (ax)
      0:       axis_code = index ? CODE_Z_INDEX : CODE_Z_SENSOR;
      1:       axis_code = index ? CODE_X_INDEX : CODE_X_SENSOR;
      2:       axis_code = index ? CODE_Y_INDEX : CODE_Y_SENSOR;
      default: axis_code = index ? CODE_R_INDEX : CODE_R_SENSOR;
    endcase
  endfunction

  logic [31:0]         steps_r [NUM_AXES];
  logic [NUM_AXES-1:0] home_ref_r;
  logic [NUM_AXES-1:0] home_chg_r;
  logic [NUM_AXES-1:0] idx_hi_r;
  logic [NUM_AXES-1:0] idx_lo_r;
  logic [NUM_AXES-1:0] moved_r;
  logic [NUM_AXES-1:0] watch_r;
  logic [NUM_AXES-1:0] limit_w;
  logic [NUM_AXES-1:0] sens_bad_w;
  logic [NUM_AXES-1:0] idx_bad_w;

  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      limit_w[a]    = watch_r[a] && step_pulse[a] &&
                      (steps_r[a] == 32'(STEP_COUNT) - 32'd1);
      sens_bad_w[a] = limit_w[a] && !home_chg_r[a] && (home_w[a] == home_ref_r[a]);
      idx_bad_w[a]  = limit_w[a] && !(idx_hi_r[a] && idx_lo_r[a]);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int a = 0; a < NUM_AXES; a++) steps_r[a] <= 32'h0000_0000;
      home_ref_r <= '0;
      home_chg_r <= '0;
      idx_hi_r   <= '0;
      idx_lo_r   <= '0;
      moved_r    <= '0;
      watch_r    <= '0;
    end else if (homing_start) begin
      for (int a = 0; a < NUM_AXES; a++) steps_r[a] <= 32'h0000_0000;
      home_ref_r <= home_w;
      home_chg_r <= '0;
      idx_hi_r   <= '0;
      idx_lo_r   <= '0;
      moved_r    <= '0;
      watch_r    <= '1;
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (watch_r[a] && step_pulse[a]) steps_r[a] <= steps_r[a] + 32'd1;
        if (limit_w[a]) watch_r[a] <= 1'b0;
        if (watch_r[a] && home_w[a] != home_ref_r[a]) home_chg_r[a] <= 1'b1;
        if (watch_r[a] && index_w[a]) idx_hi_r[a] <= 1'b1;
        if (watch_r[a] && !index_w[a]) idx_lo_r[a] <= 1'b1;
        if (watch_r[a] && moving_w[a]) moved_r[a] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault code latch: first code wins, lower axis first within a cycle
  logic              code_hit_w;
  logic [CODE_W-1:0] code_w;
  logic              motor_w;

  always_comb begin
    code_hit_w = 1'b0;
    code_w     = CODE_NONE;
    motor_w    = 1'b0;
    for (int a = NUM_AXES - 1; a >= 0; a--) begin
      if (idx_bad_w[a]) begin
        code_hit_w = 1'b1;
        code_w     = axis_code(a, 1'b1);
        motor_w    = 1'b0;
      end
      if (sens_bad_w[a]) begin
        code_hit_w = 1'b1;
        code_w     = axis_code(a, 1'b0);
        motor_w    = !(moved_r[a] || moving_w[a]);
      end
    end
    if (trap_fault) begin
      code_hit_w = 1'b1;
      code_w     = CODE_TRAP;
      motor_w    = 1'b0;
    end
    if (logic_fault) begin
      code_hit_w = 1'b1;
      code_w     = CODE_LOGIC;
      motor_w    = 1'b0;
    end
  end

  logic              valid_r;
  logic [CODE_W-1:0] code_r;
  logic              motor_r;
  logic [DETAIL_W-1:0] detail_r;
  logic              hide_r;
  logic              trap_rec_r;
  logic              pend_trap_r;
  logic              blank_r;
  logic [1:0]        boot_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      valid_r     <= 1'b0;
      code_r      <= CODE_NONE;
      motor_r     <= 1'b0;
      detail_r    <= '0;
      hide_r      <= 1'b0;
      trap_rec_r  <= 1'b0;
      pend_trap_r <= 1'b0;
      blank_r     <= 1'b0;
      boot_r      <= 2'h0;
    end else begin
      if (boot_r != 2'h3) boot_r <= boot_r + 2'h1;
      // strap caught once, at the third edge after release, when the synchroniser holds it
      if (boot_r == 2'h2 && trap_stored_w) pend_trap_r <= 1'b1;
      if (trap_fault) trap_rec_r <= 1'b1;
      blank_r <= (pat_r != PAT_NONE) || (new_pat_w != PAT_NONE);
      if (!valid_r && code_hit_w) begin
        valid_r <= 1'b1;
        code_r  <= code_w;
        motor_r <= motor_w;
        if (logic_fault) begin
          detail_r <= logic_detail;
          hide_r   <= 1'b1;
        end
      end
    end
  end

  assign buzzer_on     = bif.buzzer;
  assign display_blank = blank_r;
  assign fault_valid   = valid_r;
  assign fault_code    = code_r;
  assign fault_motor   = motor_r;
  assign fault_detail  = detail_r;
  assign prognum_hide  = hide_r;
  assign trap_record   = trap_rec_r;
  assign pendant_trap  = pend_trap_r;

  ////////////////////////////////////////////////////////////////////////////
  a_loader_pattern: assert property (@(posedge ref_clk) disable iff (!resetn)
    check_done && !checked_r && pat_r == PAT_NONE && load_mode_w && !loader_sum_ok
      |=> pat_r == PAT_ONE_LONG && start_r ##1 bif.busy ##1 buzzer_on)
    else $error("bad loader did not start one long beep");
  a_main_pattern: assert property (@(posedge ref_clk) disable iff (!resetn)
    check_done && !checked_r && pat_r == PAT_NONE && !load_mode_w && !main_sum_ok
      |=> pat_r == PAT_TWO_LONG)
    else $error("bad main program did not select two long beeps");
  a_trap_beep_code: assert property (@(posedge ref_clk) disable iff (!resetn)
    trap_fault && !logic_fault && !valid_r
      |=> trap_record && fault_code == CODE_TRAP)
    else $error("trap not recorded");
  a_first_pattern: assert property (@(posedge ref_clk) disable iff (!resetn)
    pat_r != PAT_NONE |=> $stable(pat_r))
    else $error("beep pattern replaced");
  a_beep_blanks: assert property (@(posedge ref_clk) disable iff (!resetn)
    buzzer_on |-> display_blank)
    else $error("display shown during fault beep");
  a_sensor_code: assert property (@(posedge ref_clk) disable iff (!resetn)
    !valid_r && !trap_fault && !logic_fault && sens_bad_w[0]
      |=> fault_code == CODE_Z_SENSOR && fault_motor == !(moved_r[0] || $past(moving_w[0])))
    else $error("z sensor fault code wrong");
  a_index_stuck: assert property (@(posedge ref_clk) disable iff (!resetn)
    !valid_r && !trap_fault && !logic_fault && limit_w == 4'b1000 && idx_bad_w[3]
      && !sens_bad_w[3] |=> fault_code == CODE_R_INDEX)
    else $error("r index fault code wrong");
  a_logic_detail: assert property (@(posedge ref_clk) disable iff (!resetn)
    logic_fault && !valid_r |=> fault_code == CODE_LOGIC && prognum_hide
      && fault_detail == $past(logic_detail))
    else $error("logic fault detail not kept");

  c_sensor_fault: cover property (@(posedge ref_clk) disable iff (!resetn)
    valid_r && code_r == CODE_Y_SENSOR);
  c_flash_fail: cover property (@(posedge ref_clk) disable iff (!resetn) pat_r == PAT_CONT);

endmodule
`default_nettype wire

// ---- tb/buzzer_model.sv ----
// buzzer driver model: measures how long each on and off stretch lasts
// assumes buzzer_on is registered on ref_clk; clr restarts the record
`timescale 1ns/1ps
`default_nettype none
module buzzer_model (
  input wire logic ref_clk,   // system clock
  input wire logic clr,       // restart measurement
  input wire logic buzzer_on  // buzzer drive from the block
);
  int   runs [8];
  int   n;
  int   cnt;
  logic prev;
  logic started;

  ////////////////////////////////////////////////////////////////////////////
  // recording starts at the first rise, so the idle time before it is ignored
  always @(posedge ref_clk) begin
    if (clr) begin
      n = 0;
      cnt = 0;
      prev = 1'b0;
      started = 1'b0;
    end else begin
      if (started && buzzer_on !== prev && n < 8) begin
        runs[n] = cnt;
        n++;
        cnt = 0;
      end
      if (!started && buzzer_on === 1'b1) begin
        started = 1'b1;
        cnt = 0;
      end
      cnt++;
      prev = buzzer_on;
    end
  end
endmodule
`default_nettype wire

// ---- tb/fault_beep_annunciator_tb_top.sv ----
// testbench for the fault annunciator: beep patterns and homing codes
// assumes shortened pattern and step counts so every run stays short
`timescale 1ns/1ps
`default_nettype none
module fault_beep_annunciator_tb_top;
  import beep_pkg::*;
  logic        ref_clk = 0, resetn = 0, load = 0, stored = 0, cdone = 0;
  logic        lok = 1, mok = 1, trap = 0, flash = 0, lfault = 0, hstart = 0, clr = 1;
  logic [47:0] detail = '0;
  logic [3:0]  step = '0, home = '0, index = '0, mov = '0;
  logic        buzz, blank, fvalid, fmotor, hide, trec, ptrap;
  logic [6:0]  fcode;
  logic [47:0] fdet;
  int          fails = 0, total_checks = 0;
  logic [6:0]  idx_code [4] = '{CODE_Z_INDEX, CODE_X_INDEX, CODE_Y_INDEX, CODE_R_INDEX};

  always #4 ref_clk = ~ref_clk;

  // intra-group gaps follow the on times inside the block
  fault_beep_annunciator #(.LONG_ON(6), .SHORT_ON(2), .GROUP_GAP(12), .CONT_ON(20),
    .STEP_COUNT(8)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .load_mode_pin(load), .trap_stored_pin(stored),
    .check_done(cdone), .loader_sum_ok(lok), .main_sum_ok(mok), .trap_fault(trap),
    .flash_fail(flash), .logic_fault(lfault), .logic_detail(detail),
    .homing_start(hstart), .step_pulse(step), .home_pin(home), .index_pin(index),
    .moving_pin(mov), .buzzer_on(buzz), .display_blank(blank), .fault_valid(fvalid),
    .fault_code(fcode), .fault_motor(fmotor), .fault_detail(fdet),
    .prognum_hide(hide), .trap_record(trec), .pendant_trap(ptrap));

  buzzer_model bm (.ref_clk(ref_clk), .clr(clr), .buzzer_on(buzz));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // every scenario starts from a fresh power-on, since all faults are sticky
  task automatic rst(input logic st);
    @(negedge ref_clk);
    resetn = 0; clr = 1; stored = st; load = 0; lok = 1; mok = 1;
    step = '0; home = '0; index = '0; mov = '0;
    repeat (3) @(negedge ref_clk);
    resetn = 1; clr = 0;
    repeat (3) @(negedge ref_clk);
  endtask

  // kind 0 checksum result, 1 trap, 2 flash failure; a later fault must not win
  task automatic beep(input int kind, input logic ld, input logic lo, input logic mo,
                      input int e0, input int e1, input int e2, input int e3);
    rst(0);
    load = ld;
    repeat (3) @(negedge ref_clk);
    lok = lo; mok = mo;
    cdone = (kind == 0); trap = (kind == 1); flash = (kind == 2);
    @(negedge ref_clk);
    cdone = 0; trap = 0; flash = 0;
    @(negedge ref_clk);
    cdone = 1; lok = 0; mok = 0;
    @(negedge ref_clk);
    cdone = 0;
    for (int i = 0; i < 300 && bm.n < 4; i++) @(negedge ref_clk);
    chk("first on", e0, bm.runs[0]);
    if (e1 != 0) begin
      chk("first gap", e1, bm.runs[1]);
      chk("second on", e2, bm.runs[2]);
      chk("group gap", e3, bm.runs[3]);
    end else chk("run count", 1, bm.n);
    if (kind == 0) chk("display_blank", 1, blank);
    if (kind == 1) chk("trap code", {trec, fcode}, {1'b1, CODE_TRAP});
  endtask

  // tog 0: home stuck while index toggles; tog 1: home toggles, index stuck
  // (stuck high on x and r, stuck low on z and y)
  task automatic homing(input int a, input logic tog, input logic mv,
                        input logic [6:0] code, input logic motor);
    rst(0);
    mov[a] = mv;
    index[a] = tog & a[0];
    repeat (3) @(negedge ref_clk);
    hstart = 1;
    @(negedge ref_clk);
    hstart = 0;
    for (int i = 0; i < 8; i++) begin
      home[a] = tog & i[0];
      index[a] = tog ? a[0] : i[0];
      step[a] = 1;
      @(negedge ref_clk);
      step[a] = 0;
      repeat (3) @(negedge ref_clk);
    end
    chk("fault code", {fvalid, fcode}, {1'b1, code});
    if (!tog) chk("fault_motor", motor, fmotor);
  endtask

  task automatic logic_case();
    rst(1);
    chk("pendant_trap", 1, ptrap);
    detail = 48'h4142_4344_4546; lfault = 1;
    @(negedge ref_clk);
    lfault = 0; trap = 1;
    @(negedge ref_clk);
    trap = 0;
    @(negedge ref_clk);
    chk("logic code", {fvalid, fcode, hide}, {1'b1, CODE_LOGIC, 1'b1});
    chk("detail", 48'h4142_4344_4546, fdet);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    beep(0, 0, 1, 0, 6, 6, 6, 12);
    beep(0, 1, 0, 1, 6, 12, 6, 12);
    beep(1, 0, 1, 1, 2, 2, 2, 12);
    beep(2, 1, 1, 1, 20, 0, 0, 0);
    homing(0, 0, 1, CODE_Z_SENSOR, 0);
    homing(1, 0, 0, CODE_X_SENSOR, 1);
    homing(2, 0, 1, CODE_Y_SENSOR, 0);
    homing(3, 0, 0, CODE_R_SENSOR, 1);
    for (int a = 0; a < 4; a++) homing(a, 1, 1, idx_code[a], 0);
    logic_case();
    test_done();
  end

  // the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    $display("watchdog expired");
    test_done();
  end
endmodule
`default_nettype wire
